// File: core/irq_timer_xfer_pkg.sv
// constants and carrier types for the interrupt and timer transfer executor
// *****************************************************************************
// What this block does
// - The disable-interrupt op clears the global interrupt enable flag to 0.
// - The enable-interrupt op sets the global interrupt enable flag to 1.
// - With enable bit 0 of irq_ctrl_a low, the ext0 flag test skips and clears a set flag; else NOP.
// - With enable bit 1 of irq_ctrl_a low, the ext1 flag test skips and clears a set flag; else NOP.
// - The ext0 pin test skips when the pin level equals polarity bit 2 of ext0_trigger_ctrl.
// - The ext1 pin test skips when the pin level equals polarity bit 2 of ext1_trigger_ctrl.
// - Two ops move irq_ctrl_a to the accumulator and the accumulator to irq_ctrl_a.
// - Two ops move irq_ctrl_b to the accumulator and the accumulator to irq_ctrl_b.
// - Each trigger control register can be read into and written from the accumulator.
// - The aux timer control register is write-only from the accumulator.
// - Timer control registers one to six are each readable and writable via the accumulator.
// - Reading a timer counter puts its high nibble in B and low nibble in the accumulator.
// - A dedicated op loads only timer 1's reload register from B and the accumulator.
// - A dedicated op loads only timer 3's reload register from B and the accumulator.
// - A dedicated op loads timer 4's high reload register from B and the accumulator.
// *****************************************************************************
package irq_timer_xfer_pkg;

	localparam int NIB_W   = 4;
	localparam int OP_W    = 10;
	localparam int BYTE_W  = 8;
	localparam int N_TIMER = 4;
	localparam int N_WCTRL = 6;

	// *************************************************************************
	// opcodes
	// *************************************************************************
	localparam logic [OP_W-1:0] OP_IE_CLR = 10'h004;
	localparam logic [OP_W-1:0] OP_IE_SET = 10'h005;
	localparam logic [OP_W-1:0] OP_F0_TST = 10'h038;
	localparam logic [OP_W-1:0] OP_F1_TST = 10'h039;
	localparam logic [OP_W-1:0] OP_SNZP0  = 10'h03A;
	localparam logic [OP_W-1:0] OP_SNZP1  = 10'h03B;
	localparam logic [OP_W-1:0] OP_RD_VA  = 10'h054;
	localparam logic [OP_W-1:0] OP_WR_VA  = 10'h03F;
	localparam logic [OP_W-1:0] OP_RD_VB  = 10'h055;
	localparam logic [OP_W-1:0] OP_WR_VB  = 10'h03E;
	localparam logic [OP_W-1:0] OP_RD_T0  = 10'h253;
	localparam logic [OP_W-1:0] OP_WR_T0  = 10'h217;
	localparam logic [OP_W-1:0] OP_RD_T1  = 10'h254;
	localparam logic [OP_W-1:0] OP_WR_T1  = 10'h218;
	localparam logic [OP_W-1:0] OP_WR_AUX = 10'h2AA;
	localparam logic [OP_W-1:0] OP_RD_TC1 = 10'h24B; // timer ctrl one..six read, consecutive
	localparam logic [OP_W-1:0] OP_WR_TC1 = 10'h20E; // timer ctrl one..six write, consecutive
	localparam logic [OP_W-1:0] OP_RD_CNT = 10'h270; // timers 1..4 consecutive
	localparam logic [OP_W-1:0] OP_WR_CNT = 10'h230; // timers 1..4 consecutive
	localparam logic [OP_W-1:0] OP_T4H_LD = 10'h237;
	localparam logic [OP_W-1:0] OP_T1R_LD = 10'h23F;
	localparam logic [OP_W-1:0] OP_T3R_LD = 10'h23B;

	// *************************************************************************
	// field positions and reset values
	// *************************************************************************
	localparam int EXT0_EN_BIT  = 0;
	localparam int EXT1_EN_BIT  = 1;
	localparam int POLARITY_BIT = 2;
	localparam int T1_IDX       = 0;
	localparam int T3_IDX       = 2;
	localparam int T4_IDX       = 3;

	localparam logic [NIB_W-1:0]  RST_NIB  = 4'h0;
	localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;

	// *************************************************************************
	// register port map
	// *************************************************************************
	localparam int BUS_AW = 3;
	localparam logic [BUS_AW-1:0] ADDR_STATUS = 3'h0; // rd: flags, w1c: request flags
	localparam logic [BUS_AW-1:0] ADDR_VCTRL  = 3'h1; // rd: {irq_ctrl_b, irq_ctrl_a}
	localparam logic [BUS_AW-1:0] ADDR_TRIG   = 3'h2; // rd: {ext1, ext0 trigger ctrl}
	localparam logic [BUS_AW-1:0] ADDR_AUX    = 3'h3; // rd: aux timer control
	localparam int ST_IE_BIT   = 0;
	localparam int ST_F0_BIT   = 1;
	localparam int ST_F1_BIT   = 2;
	localparam int ST_PIN0_BIT = 3;
	localparam int ST_PIN1_BIT = 4;

	typedef struct packed {
		logic              valid;
		logic [OP_W-1:0]   code;
		logic [NIB_W-1:0]  acc;
		logic [NIB_W-1:0]  breg;
	} op_req_t;

	typedef struct packed {
		logic              acc_wr;
		logic [NIB_W-1:0]  acc;
		logic              breg_wr;
		logic [NIB_W-1:0]  breg;
		logic              skip;
	} op_res_t;

endpackage : irq_timer_xfer_pkg

// File: core/irq_timer_xfer.sv
// executor for interrupt control and timer transfer instructions
`timescale 1ns/1ps

module irq_timer_xfer #(
	parameter int DATA_W = 8
) (
	input  wire logic                                   sys_clk_i,
	input  wire logic                                   sys_rst_i,
	input  wire irq_timer_xfer_pkg::op_req_t            op_i,
	output irq_timer_xfer_pkg::op_res_t                 res_o,
	input  wire logic                                   ext0_set_i,
	input  wire logic                                   ext1_set_i,
	input  wire logic                                   ext_irq_pin_zero_i,
	input  wire logic                                   ext_irq_pin_one_i,
	input  wire logic [irq_timer_xfer_pkg::N_TIMER-1:0]
	             [irq_timer_xfer_pkg::BYTE_W-1:0]        timer_count_i,
	output logic                                        global_irq_enable_flag_o,
	output logic                                        ext0_request_flag_o,
	output logic                                        ext1_request_flag_o,
	output logic [irq_timer_xfer_pkg::NIB_W-1:0]        irq_ctrl_a_o,
	output logic [irq_timer_xfer_pkg::NIB_W-1:0]        irq_ctrl_b_o,
	output logic [irq_timer_xfer_pkg::NIB_W-1:0]        ext0_trigger_ctrl_o,
	output logic [irq_timer_xfer_pkg::NIB_W-1:0]        ext1_trigger_ctrl_o,
	output logic                                        aux_timer_ctrl_o,
	output logic [irq_timer_xfer_pkg::N_WCTRL-1:0]
	             [irq_timer_xfer_pkg::NIB_W-1:0]         timer_ctrl_o,
	output logic [irq_timer_xfer_pkg::N_TIMER-1:0]
	             [irq_timer_xfer_pkg::BYTE_W-1:0]        timer_reload_o,
	output logic [irq_timer_xfer_pkg::BYTE_W-1:0]        timer4_high_reload_o,
	output logic [irq_timer_xfer_pkg::N_TIMER-1:0]       timer_cnt_wr_o,
	output logic [irq_timer_xfer_pkg::BYTE_W-1:0]        timer_cnt_data_o,
	input  wire logic [irq_timer_xfer_pkg::BUS_AW-1:0]   bus_addr_i,
	input  wire logic [DATA_W-1:0]                      bus_wdata_i,
	input  wire logic                                   bus_wr_i,
	input  wire logic                                   bus_rd_i,
	output logic [DATA_W-1:0]                           bus_rdata_o
);

	// *************************************************************************
	// decode helpers
	// *************************************************************************
	function automatic logic op_is(
		input irq_timer_xfer_pkg::op_req_t     req,
		input logic [irq_timer_xfer_pkg::OP_W-1:0] code
	);
		op_is = req.valid && (req.code == code);
	endfunction : op_is

	// idx adds modulo the opcode width, so a base near the top would wrap
	function automatic logic op_at(
		input irq_timer_xfer_pkg::op_req_t     req,
		input logic [irq_timer_xfer_pkg::OP_W-1:0] base,
		input int                              idx
	);
		op_at = op_is(req, base + irq_timer_xfer_pkg::OP_W'(idx));
	endfunction : op_at

	// *************************************************************************
	// pin synchronisers
	// *************************************************************************
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;

	// the pin tests see a level one to two cycles after it reaches the pin
	always_ff @(posedge sys_clk_i)
	begin
		pin_meta <= {ext_irq_pin_one_i, ext_irq_pin_zero_i};
		pin_sync <= pin_meta;
	end

	// *************************************************************************
	// skip conditions
	// *************************************************************************
	logic skip_f0;
	logic skip_f1;
	logic skip_p0;
	logic skip_p1;

	// an enabled source is serviced by the interrupt itself, so the test is a no-op
	// the skip itself is a one-cycle pulse; the core drops the next word
	assign skip_f0 = op_is(op_i, irq_timer_xfer_pkg::OP_F0_TST)
		&& !irq_ctrl_a_o[irq_timer_xfer_pkg::EXT0_EN_BIT] && ext0_request_flag_o;
	assign skip_f1 = op_is(op_i, irq_timer_xfer_pkg::OP_F1_TST)
		&& !irq_ctrl_a_o[irq_timer_xfer_pkg::EXT1_EN_BIT] && ext1_request_flag_o;
	assign skip_p0 = op_is(op_i, irq_timer_xfer_pkg::OP_SNZP0)
		&& (pin_sync[0] == ext0_trigger_ctrl_o[irq_timer_xfer_pkg::POLARITY_BIT]);
	assign skip_p1 = op_is(op_i, irq_timer_xfer_pkg::OP_SNZP1)
		&& (pin_sync[1] == ext1_trigger_ctrl_o[irq_timer_xfer_pkg::POLARITY_BIT]);

	// *************************************************************************
	// accumulator / B result, one cycle after the op
	// *************************************************************************
	// nibble split of byte-wide timer values: B takes the high half, A the low
	localparam int NIB_HI_MSB = irq_timer_xfer_pkg::BYTE_W - 1;
	localparam int NIB_HI_LSB = irq_timer_xfer_pkg::NIB_W;
	localparam int NIB_LO_MSB = irq_timer_xfer_pkg::NIB_W - 1;

	irq_timer_xfer_pkg::op_res_t next_res;

	always_comb
	begin
		next_res      = '0;
		next_res.skip = skip_f0 || skip_f1 || skip_p0 || skip_p1;
		if (op_is(op_i, irq_timer_xfer_pkg::OP_RD_VA))
		begin
			next_res.acc_wr = 1'b1;
			next_res.acc    = irq_ctrl_a_o;
		end
		if (op_is(op_i, irq_timer_xfer_pkg::OP_RD_VB))
		begin
			next_res.acc_wr = 1'b1;
			next_res.acc    = irq_ctrl_b_o;
		end
		if (op_is(op_i, irq_timer_xfer_pkg::OP_RD_T0))
		begin
			next_res.acc_wr = 1'b1;
			next_res.acc    = ext0_trigger_ctrl_o;
		end
		if (op_is(op_i, irq_timer_xfer_pkg::OP_RD_T1))
		begin
			next_res.acc_wr = 1'b1;
			next_res.acc    = ext1_trigger_ctrl_o;
		end
		// timer control one to six sit at consecutive codes from the base
		for (int i = 0; i < irq_timer_xfer_pkg::N_WCTRL; i++)
		begin
			if (op_at(op_i, irq_timer_xfer_pkg::OP_RD_TC1, i))
			begin
				next_res.acc_wr = 1'b1;
				next_res.acc    = timer_ctrl_o[i];
			end
		end
		for (int i = 0; i < irq_timer_xfer_pkg::N_TIMER; i++)
		begin
			if (op_at(op_i, irq_timer_xfer_pkg::OP_RD_CNT, i))
			begin
				next_res.acc_wr  = 1'b1;
				next_res.breg_wr = 1'b1;
				next_res.breg    = timer_count_i[i][NIB_HI_MSB:NIB_HI_LSB];
				next_res.acc     = timer_count_i[i][NIB_LO_MSB:0];
			end
		end
	end

	// every op resolves in the cycle after it is presented
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			res_o <= '0;
		else
			res_o <= next_res;
	end

	// *************************************************************************
	// interrupt enable and request flags
	// *************************************************************************
	// disable is decoded first, so one slot can never leave the flag set
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			global_irq_enable_flag_o <= 1'b0;
		else if (op_is(op_i, irq_timer_xfer_pkg::OP_IE_CLR))
			global_irq_enable_flag_o <= 1'b0;
		else if (op_is(op_i, irq_timer_xfer_pkg::OP_IE_SET))
			global_irq_enable_flag_o <= 1'b1;
	end

	logic bus_clr_f0;
	logic bus_clr_f1;

	assign bus_clr_f0 = bus_wr_i && (bus_addr_i == irq_timer_xfer_pkg::ADDR_STATUS)
		&& bus_wdata_i[irq_timer_xfer_pkg::ST_F0_BIT];
	assign bus_clr_f1 = bus_wr_i && (bus_addr_i == irq_timer_xfer_pkg::ADDR_STATUS)
		&& bus_wdata_i[irq_timer_xfer_pkg::ST_F1_BIT];

	// a new request in the clearing cycle must survive, so set wins
	// a skip is still reported when a fresh set keeps the flag high
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ext0_request_flag_o <= 1'b0;
			ext1_request_flag_o <= 1'b0;
		end
		else
		begin
			if (ext0_set_i)
				ext0_request_flag_o <= 1'b1;
			else if (skip_f0 || bus_clr_f0)
				ext0_request_flag_o <= 1'b0;
			if (ext1_set_i)
				ext1_request_flag_o <= 1'b1;
			else if (skip_f1 || bus_clr_f1)
				ext1_request_flag_o <= 1'b0;
		end
	end

	// *************************************************************************
	// interrupt control registers
	// *************************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			irq_ctrl_a_o        <= irq_timer_xfer_pkg::RST_NIB;
			irq_ctrl_b_o        <= irq_timer_xfer_pkg::RST_NIB;
			ext0_trigger_ctrl_o <= irq_timer_xfer_pkg::RST_NIB;
			ext1_trigger_ctrl_o <= irq_timer_xfer_pkg::RST_NIB;
		end
		else
		begin
			if (op_is(op_i, irq_timer_xfer_pkg::OP_WR_VA))
				irq_ctrl_a_o <= op_i.acc;
			if (op_is(op_i, irq_timer_xfer_pkg::OP_WR_VB))
				irq_ctrl_b_o <= op_i.acc;
			if (op_is(op_i, irq_timer_xfer_pkg::OP_WR_T0))
				ext0_trigger_ctrl_o <= op_i.acc;
			if (op_is(op_i, irq_timer_xfer_pkg::OP_WR_T1))
				ext1_trigger_ctrl_o <= op_i.acc;
		end
	end

	// *************************************************************************
	// timer control registers
	// *************************************************************************
	// only bit 0 of A is kept; no op reads it back, only the aux address of the register port does
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			aux_timer_ctrl_o <= 1'b0;
		else if (op_is(op_i, irq_timer_xfer_pkg::OP_WR_AUX))
			aux_timer_ctrl_o <= op_i.acc[0];
	end

	genvar gw;
	generate
		for (gw = 0; gw < irq_timer_xfer_pkg::N_WCTRL; gw++)
		begin : g_wctrl
			always_ff @(posedge sys_clk_i)
			begin
				if (sys_rst_i)
					timer_ctrl_o[gw] <= irq_timer_xfer_pkg::RST_NIB;
				else if (op_at(op_i, irq_timer_xfer_pkg::OP_WR_TC1, gw))
					timer_ctrl_o[gw] <= op_i.acc;
			end
		end
	endgenerate

	// *************************************************************************
	// timer reload and counter loads
	// *************************************************************************
	// reload-only ops share the reload path with the combined counter writes
	logic [irq_timer_xfer_pkg::N_TIMER-1:0] reload_only;

	always_comb
	begin
		reload_only = '0;
		reload_only[irq_timer_xfer_pkg::T1_IDX] =
			op_is(op_i, irq_timer_xfer_pkg::OP_T1R_LD);
		reload_only[irq_timer_xfer_pkg::T3_IDX] =
			op_is(op_i, irq_timer_xfer_pkg::OP_T3R_LD);
	end

	genvar gt;
	generate
		for (gt = 0; gt < irq_timer_xfer_pkg::N_TIMER; gt++)
		begin : g_reload
			always_ff @(posedge sys_clk_i)
			begin
				if (sys_rst_i)
					timer_reload_o[gt] <= irq_timer_xfer_pkg::RST_BYTE;
				else if (op_at(op_i, irq_timer_xfer_pkg::OP_WR_CNT, gt) || reload_only[gt])
					timer_reload_o[gt] <= {op_i.breg, op_i.acc};
			end
		end
	endgenerate

	// counter load is a pulse; reload-only ops leave the running count alone
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			timer_cnt_wr_o   <= '0;
			timer_cnt_data_o <= irq_timer_xfer_pkg::RST_BYTE;
		end
		else
		begin
			for (int i = 0; i < irq_timer_xfer_pkg::N_TIMER; i++)
				timer_cnt_wr_o[i] <= op_at(op_i, irq_timer_xfer_pkg::OP_WR_CNT, i);
			timer_cnt_data_o <= {op_i.breg, op_i.acc};
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			timer4_high_reload_o <= irq_timer_xfer_pkg::RST_BYTE;
		else if (op_is(op_i, irq_timer_xfer_pkg::OP_T4H_LD))
			timer4_high_reload_o <= {op_i.breg, op_i.acc};
	end

	// *************************************************************************
	// register port
	// *************************************************************************
	// status writes only clear request flags; writes elsewhere are dropped
	logic [DATA_W-1:0] next_rdata;

	always_comb
	begin
		next_rdata = '0;
		unique case (bus_addr_i)
			irq_timer_xfer_pkg::ADDR_STATUS:
			begin
				next_rdata[irq_timer_xfer_pkg::ST_IE_BIT]   = global_irq_enable_flag_o;
				next_rdata[irq_timer_xfer_pkg::ST_F0_BIT]   = ext0_request_flag_o;
				next_rdata[irq_timer_xfer_pkg::ST_F1_BIT]   = ext1_request_flag_o;
				next_rdata[irq_timer_xfer_pkg::ST_PIN0_BIT] = pin_sync[0];
				next_rdata[irq_timer_xfer_pkg::ST_PIN1_BIT] = pin_sync[1];
			end
			irq_timer_xfer_pkg::ADDR_VCTRL:
				next_rdata[NIB_HI_MSB:0] = {irq_ctrl_b_o, irq_ctrl_a_o};
			irq_timer_xfer_pkg::ADDR_TRIG:
				next_rdata[NIB_HI_MSB:0] = {ext1_trigger_ctrl_o, ext0_trigger_ctrl_o};
			irq_timer_xfer_pkg::ADDR_AUX:
				next_rdata[0] = aux_timer_ctrl_o;
			// addresses four to seven are unmapped and read as zero
			default:
				next_rdata = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	// zero between reads keeps a stale value off the shared data lines
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			bus_rdata_o <= '0;
		else if (bus_rd_i)
			bus_rdata_o <= next_rdata;
		else
			bus_rdata_o <= '0;
	end

endmodule : irq_timer_xfer

// File: verification/irq_timer_xfer_sva.sv
// assertion checker for the interrupt and timer transfer executor
`timescale 1ns/1ps

module irq_timer_xfer_sva (
	input wire logic                        sys_clk_i,
	input wire logic                        sys_rst_i,
	input wire irq_timer_xfer_pkg::op_req_t op_i,
	input wire irq_timer_xfer_pkg::op_res_t res_o,
	input wire logic                        ext0_set_i,
	input wire logic                        ext_irq_pin_zero_i,
	input wire logic [3:0][7:0]             timer_count_i,
	input wire logic                        global_irq_enable_flag_o,
	input wire logic                        ext0_request_flag_o,
	input wire logic                        ext1_request_flag_o,
	input wire logic [3:0]                  irq_ctrl_a_o,
	input wire logic [3:0]                  ext0_trigger_ctrl_o,
	input wire logic                        aux_timer_ctrl_o,
	input wire logic [3:0][7:0]             timer_reload_o,
	input wire logic [3:0]                  timer_cnt_wr_o,
	input wire logic [7:0]                  timer_cnt_data_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// 3FF is no opcode, so an idle slot never matches a decode below
	wire logic [9:0] oc = op_i.valid ? op_i.code : 10'h3FF;

	a_disable_clears_ie: assert property (
		oc == irq_timer_xfer_pkg::OP_IE_CLR |=> !global_irq_enable_flag_o)
		else $error("ie not cleared");
	a_enable_sets_ie: assert property (
		oc == irq_timer_xfer_pkg::OP_IE_SET |=> global_irq_enable_flag_o)
		else $error("ie not set");
	a_flag0_skip: assert property (
		oc == irq_timer_xfer_pkg::OP_F0_TST
		|=> res_o.skip == ($past(ext0_request_flag_o) && !$past(irq_ctrl_a_o[0])))
		else $error("ext0 flag skip wrong");
	a_flag0_clear: assert property (
		oc == irq_timer_xfer_pkg::OP_F0_TST && ext0_request_flag_o && !irq_ctrl_a_o[0] && !ext0_set_i
		|=> !ext0_request_flag_o) else $error("ext0 flag not cleared");
	a_flag1_skip: assert property (
		oc == irq_timer_xfer_pkg::OP_F1_TST
		|=> res_o.skip == ($past(ext1_request_flag_o) && !$past(irq_ctrl_a_o[1])))
		else $error("ext1 flag skip wrong");
	a_pin0_skip: assert property (
		$stable(ext_irq_pin_zero_i) [*5] ##0 oc == irq_timer_xfer_pkg::OP_SNZP0
		|=> res_o.skip == ($past(ext_irq_pin_zero_i) == $past(ext0_trigger_ctrl_o[2])))
		else $error("pin0 skip wrong");
	a_aux_write: assert property (
		oc == irq_timer_xfer_pkg::OP_WR_AUX |=> aux_timer_ctrl_o == $past(op_i.acc[0]))
		else $error("aux ctrl write wrong");
	a_cnt_read: assert property (
		oc == irq_timer_xfer_pkg::OP_RD_CNT |=> res_o.acc_wr && res_o.breg_wr
		&& {res_o.breg, res_o.acc} == $past(timer_count_i[0])) else $error("count read wrong");
	a_t1_reload_only: assert property (
		oc == irq_timer_xfer_pkg::OP_T1R_LD |=> timer_cnt_wr_o == 4'h0
		&& timer_reload_o[0] == $past({op_i.breg, op_i.acc})) else $error("t1 reload wrong");
	a_combined_wr: assert property (
		oc == irq_timer_xfer_pkg::OP_WR_CNT |=> timer_cnt_wr_o == 4'h1
		&& timer_cnt_data_o == $past({op_i.breg, op_i.acc}) && timer_reload_o[0] == timer_cnt_data_o)
		else $error("combined write wrong");
	a_idle_quiet: assert property (
		!op_i.valid |=> res_o == '0 && timer_cnt_wr_o == 4'h0) else $error("result outlives op");
endmodule : irq_timer_xfer_sva

bind irq_timer_xfer irq_timer_xfer_sva u_sva (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.op_i(op_i), .res_o(res_o), .ext0_set_i(ext0_set_i), .ext_irq_pin_zero_i(ext_irq_pin_zero_i),
	.timer_count_i(timer_count_i), .global_irq_enable_flag_o(global_irq_enable_flag_o),
	.ext0_request_flag_o(ext0_request_flag_o), .ext1_request_flag_o(ext1_request_flag_o),
	.irq_ctrl_a_o(irq_ctrl_a_o), .ext0_trigger_ctrl_o(ext0_trigger_ctrl_o),
	.aux_timer_ctrl_o(aux_timer_ctrl_o), .timer_reload_o(timer_reload_o),
	.timer_cnt_wr_o(timer_cnt_wr_o), .timer_cnt_data_o(timer_cnt_data_o));

// File: verification/irq_timer_xfer_tb_top.sv
// self-checking bench for the interrupt and timer transfer executor
`timescale 1ns/1ps

module irq_timer_xfer_tb_top;
	logic                        sys_clk_i = 1'b0;
	logic                        sys_rst_i = 1'b1;
	irq_timer_xfer_pkg::op_req_t op_i = '0;
	irq_timer_xfer_pkg::op_res_t res_o;
	logic [1:0]                  set_i = 2'b00;
	logic                        pin0 = 1'b0;
	logic                        pin1 = 1'b0;
	logic [3:0][7:0]             cnt_i = {8'h4C, 8'h3B, 8'h2A, 8'h19};
	logic                        ie, f0, f1, aux;
	logic [3:0]                  va, vb, t0, t1, cwr;
	logic [5:0][3:0]             wctl;
	logic [3:0][7:0]             rld;
	logic [7:0]                  hrld, cdat, rdata;
	logic [2:0]                  addr = 3'h0;
	logic [7:0]                  wdata = 8'h00;
	logic                        wr = 1'b0;
	logic                        rd = 1'b0;
	int                          num_errors = 0;
	int                          compares = 0;

	always #5 sys_clk_i = ~sys_clk_i;

	irq_timer_xfer dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .op_i(op_i), .res_o(res_o),
		.ext0_set_i(set_i[0]), .ext1_set_i(set_i[1]), .ext_irq_pin_zero_i(pin0),
		.ext_irq_pin_one_i(pin1), .timer_count_i(cnt_i), .global_irq_enable_flag_o(ie),
		.ext0_request_flag_o(f0), .ext1_request_flag_o(f1), .irq_ctrl_a_o(va), .irq_ctrl_b_o(vb),
		.ext0_trigger_ctrl_o(t0), .ext1_trigger_ctrl_o(t1), .aux_timer_ctrl_o(aux),
		.timer_ctrl_o(wctl), .timer_reload_o(rld), .timer4_high_reload_o(hrld),
		.timer_cnt_wr_o(cwr), .timer_cnt_data_o(cdat), .bus_addr_i(addr), .bus_wdata_i(wdata),
		.bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// result pulse is sampled just after the edge that registers it
	task automatic op(input logic [9:0] code, input logic [3:0] a, input logic [3:0] b);
		@(posedge sys_clk_i);
		op_i <= {1'b1, code, a, b};
		@(posedge sys_clk_i);
		op_i.valid <= 1'b0;
		#1;
	endtask : op

	task automatic bwr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask : bwr

	task automatic brd(input logic [2:0] ad, input logic [7:0] exp);
		@(posedge sys_clk_i);
		addr <= ad;
		rd <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		#1;
		chk(16'(rdata), 16'(exp));
	endtask : brd

	task automatic setf(input logic [1:0] m);
		@(posedge sys_clk_i);
		set_i <= m;
		@(posedge sys_clk_i);
		set_i <= 2'b00;
	endtask : setf

	task automatic summarize();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		num_errors++;
		summarize();
	end

	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		op(irq_timer_xfer_pkg::OP_IE_SET, 4'h0, 4'h0);
		chk(16'(ie), 16'h0001);
		op(irq_timer_xfer_pkg::OP_IE_CLR, 4'h0, 4'h0);
		chk(16'(ie), 16'h0000);
		setf(2'b11);
		op(irq_timer_xfer_pkg::OP_F0_TST, 4'h0, 4'h0);
		chk(16'({res_o.skip, f0}), 16'h0002);
		op(irq_timer_xfer_pkg::OP_F0_TST, 4'h0, 4'h0);
		chk(16'(res_o.skip), 16'h0000);
		op(irq_timer_xfer_pkg::OP_WR_VA, 4'h1, 4'h0);
		chk(16'(va), 16'h0001);
		op(irq_timer_xfer_pkg::OP_RD_VA, 4'h0, 4'h0);
		chk(16'({res_o.acc_wr, res_o.acc}), 16'h0011);
		op(irq_timer_xfer_pkg::OP_F1_TST, 4'h0, 4'h0);
		chk(16'({res_o.skip, f1}), 16'h0002);
		setf(2'b01);
		op(irq_timer_xfer_pkg::OP_F0_TST, 4'h0, 4'h0);
		chk(16'({res_o.skip, f0}), 16'h0001);
		op(irq_timer_xfer_pkg::OP_WR_VA, 4'h2, 4'h0);
		setf(2'b10);
		op(irq_timer_xfer_pkg::OP_F1_TST, 4'h0, 4'h0);
		chk(16'({res_o.skip, f1}), 16'h0001);
		brd(irq_timer_xfer_pkg::ADDR_STATUS, 8'h06);
		bwr(irq_timer_xfer_pkg::ADDR_STATUS, 8'h06);
		brd(irq_timer_xfer_pkg::ADDR_STATUS, 8'h00);
		op(irq_timer_xfer_pkg::OP_WR_VB, 4'h9, 4'h0);
		op(irq_timer_xfer_pkg::OP_RD_VB, 4'h0, 4'h0);
		chk(16'({res_o.acc_wr, res_o.acc}), 16'h0019);
		bwr(3'h6, 8'hFF);
		brd(irq_timer_xfer_pkg::ADDR_VCTRL, 8'h92);
		brd(3'h5, 8'h00);
		// pins settle through the synchroniser before each pin test
		for (int k = 0; k < 4; k++)
		begin
			@(posedge sys_clk_i);
			pin0 <= k[0];
			pin1 <= k[0];
			op(irq_timer_xfer_pkg::OP_WR_T0, {1'b0, k[1], 2'b01}, 4'h0);
			op(irq_timer_xfer_pkg::OP_WR_T1, {1'b0, k[1], 2'b10}, 4'h0);
			repeat (5) @(posedge sys_clk_i);
			op(irq_timer_xfer_pkg::OP_SNZP0, 4'h0, 4'h0);
			chk(16'(res_o.skip), 16'(k[0] == k[1]));
			op(irq_timer_xfer_pkg::OP_SNZP1, 4'h0, 4'h0);
			chk(16'(res_o.skip), 16'(k[0] == k[1]));
			op(irq_timer_xfer_pkg::OP_RD_T1, 4'h0, 4'h0);
			chk(16'(res_o.acc), 16'({1'b0, k[1], 2'b10}));
			op(irq_timer_xfer_pkg::OP_RD_T0, 4'h0, 4'h0);
			chk(16'({res_o.acc_wr, res_o.acc}), 16'({2'b10, k[1], 2'b01}));
		end
		brd(irq_timer_xfer_pkg::ADDR_TRIG, 8'h65);
		brd(irq_timer_xfer_pkg::ADDR_STATUS, 8'h18);
		for (int i = 0; i < 6; i++)
		begin
			op(irq_timer_xfer_pkg::OP_WR_TC1 + 10'(i), 4'(i + 3), 4'h0);
			op(irq_timer_xfer_pkg::OP_RD_TC1 + 10'(i), 4'h0, 4'h0);
			chk(16'({wctl[i], res_o.acc}), 16'((i + 3) * 17));
		end
		op(irq_timer_xfer_pkg::OP_WR_AUX, 4'hF, 4'h0);
		chk(16'({aux, res_o.acc_wr}), 16'h0002);
		brd(irq_timer_xfer_pkg::ADDR_AUX, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			op(irq_timer_xfer_pkg::OP_RD_CNT + 10'(i), 4'h0, 4'h0);
			chk({res_o.breg_wr, res_o.breg, res_o.acc}, {8'h01, cnt_i[i]});
			op(irq_timer_xfer_pkg::OP_WR_CNT + 10'(i), 4'(i), 4'hA);
			chk({rld[i], cdat}, {2{4'hA, 4'(i)}});
			chk(16'(cwr), 16'(1 << i));
			@(posedge sys_clk_i);
			#1;
			chk(16'({res_o, cwr}), 16'h0000);
		end
		op(irq_timer_xfer_pkg::OP_T1R_LD, 4'h7, 4'hE);
		chk({rld[0], 4'h0, cwr}, 16'hE700);
		op(irq_timer_xfer_pkg::OP_T3R_LD, 4'h3, 4'hC);
		chk({rld[2], 4'h0, cwr}, 16'hC300);
		op(irq_timer_xfer_pkg::OP_T4H_LD, 4'h5, 4'hD);
		chk({hrld, rld[3]}, 16'hD5A3);
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		op(irq_timer_xfer_pkg::OP_IE_SET, 4'h0, 4'h0);
		chk({rld[0], va, 3'h0, ie}, 16'h0001);
		summarize();
	end
endmodule : irq_timer_xfer_tb_top
